// [inc/srls_link_if.sv]
// pin bundle between controller and radio
`timescale 1ns/1ps
interface srls_link_if;
  logic radioEnable;
  logic receiverEnable;
  logic transmitterEnable;
  logic synthShiftClock;
  logic synthSerialBits;
  logic synthLoadStrobe;
  logic radioTxSerialIn;
  logic radioRxSerialOut;
  modport ctrl (
    output radioEnable,
    output receiverEnable,
    output transmitterEnable,
    output synthShiftClock,
    output synthSerialBits,
    output synthLoadStrobe,
    output radioTxSerialIn,
    input radioRxSerialOut
  );
  modport radio (
    input radioEnable,
    input receiverEnable,
    input transmitterEnable,
    input synthShiftClock,
    input synthSerialBits,
    input synthLoadStrobe,
    input radioTxSerialIn,
    output radioRxSerialOut
  );
endinterface

// [inc/srls_pkg.sv]
// shared constants and types for the sensor radio link sequencer
// ****************************************************************
// Overview of operation
// - controller raises receiver and radio enable first
// - synthesizer loaded as two strobed 11-bit groups
// - controller waits a fixed 5 ms for lock
// - transmit: drop receiver enable, raise transmitter enable
// - wait 100 us settling before serial data
// - transmit bytes only after settling wait ends
// - transmit end drops radio and transmitter enable
// - receive: enables, wait 100 us, program, lock
// - radio discards stale uart bytes until lock
// - radio delivers bytes; controller then drops enables
// - serial exchange runs at 57600 baud
// - message transfer limited to 8 ms (transmit has no timer, only the msgLen check)
// - frame: start, 8 data lsb first, parity, stop
// - radio enables are active high
// ****************************************************************
package srls_pkg;
  localparam int CLK_HZ = 50000000;
  localparam int BAUD = 57600;
  localparam int BAUD_DIV = CLK_HZ / BAUD;
  localparam int LOCK_WAIT_US = 5000;
  localparam int SETTLE_US = 100;
  localparam int MSG_LIMIT_US = 8000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int LOCK_CYC = LOCK_WAIT_US * CYC_PER_US;
  localparam int SETTLE_CYC = SETTLE_US * CYC_PER_US;
  localparam int MSG_LIMIT_CYC = MSG_LIMIT_US * CYC_PER_US;
  localparam int FRAME_BITS = 11;
  localparam int SYN_GROUP_BITS = 11;
  localparam int SYN_WORD_BITS = 22;
  localparam int SYN_HALF_DIV = 25;
  localparam int TIMER_W = 24;
  localparam logic PARITY_ODD = 1'b0;
  localparam int FRAME_CYC = FRAME_BITS * BAUD_DIV;
  localparam int MAX_MSG_BYTES = MSG_LIMIT_CYC / FRAME_CYC;
  typedef logic [7:0] srls_byte_t;
endpackage

// [rtl/srls_ctrl_end.sv]
// controller end: sequences enables, synthesizer load, settle, serial bytes
`timescale 1ns/1ps
module srls_ctrl_end
  import srls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  srls_link_if.ctrl link,
  input wire logic startTx,
  input wire logic startRx,
  input wire logic [21:0] synthCfg,
  input wire logic [7:0] msgLen,
  input wire srls_pkg::srls_byte_t txData,
  input wire logic txValid,
  output logic txReady,
  output srls_pkg::srls_byte_t rxData,
  output logic rxErr,
  output logic rxValid,
  input wire logic rxReady,
  output logic busy,
  output logic lenError
);
  import srls_pkg::*;
  // ****************************************************************
  // sequencer
  // ****************************************************************
  typedef enum logic [3:0] {
    C_IDLE = 4'b0000, C_PREWAIT = 4'b0001, C_SHIFT = 4'b0010, C_STROBE = 4'b0011,
    C_LOCK = 4'b0100, C_SWITCH = 4'b0101, C_DATA = 4'b0110, C_DONE = 4'b0111
  } srls_ctrl_e;
  srls_ctrl_e st_q, st_d;
  logic isTx_q, isTx_d, rfOn_q, rfOn_d, rcvOn_q, rcvOn_d, xmtOn_q, xmtOn_d;
  logic sClk_q, sClk_d, sDat_q, sDat_d, sStb_q, sStb_d, grp_q, grp_d;
  logic [TIMER_W-1:0] tmr_q, tmr_d;
  logic [4:0] sbit_q, sbit_d;
  logic [5:0] div_q, div_d;
  logic [21:0] cfg_q, cfg_d;
  logic [7:0] left_q, left_d;
  logic lenErr_q, lenErr_d;
  logic txGo, txBusy, txDone;
  logic [3:0] tbit_q, tbit_d;
  logic [15:0] baud_q, baud_d;
  logic [10:0] frame_q, frame_d;
  logic line_q, line_d, tBusy_q, tBusy_d;
  logic rValid, rAccept;
  always_comb
  begin
    st_d = st_q;
    isTx_d = isTx_q;
    rfOn_d = rfOn_q;
    rcvOn_d = rcvOn_q;
    xmtOn_d = xmtOn_q;
    sClk_d = sClk_q;
    sDat_d = sDat_q;
    sStb_d = 1'b0;
    grp_d = grp_q;
    tmr_d = (tmr_q != '0) ? tmr_q - 1'b1 : tmr_q;
    sbit_d = sbit_q;
    div_d = div_q;
    cfg_d = cfg_q;
    left_d = left_q;
    lenErr_d = lenErr_q;
    txGo = 1'b0;
    unique case (st_q)
      C_IDLE:
      begin
        if (startTx || startRx)
        begin
          isTx_d = startTx;
          lenErr_d = 1'b0;
          if (startTx && msgLen > 8'(MAX_MSG_BYTES))
            lenErr_d = 1'b1;
          else
          begin
            rfOn_d = 1'b1;
            rcvOn_d = 1'b1;
            cfg_d = synthCfg;
            left_d = msgLen;
            tmr_d = startTx ? '0 : TIMER_W'(SETTLE_CYC);
            grp_d = 1'b0;
            st_d = C_PREWAIT;
          end
        end
      end
      C_PREWAIT:
        if (tmr_q == '0)
        begin
          st_d = C_SHIFT;
          sbit_d = '0;
          div_d = '0;
        end
      C_SHIFT:
      begin
        div_d = div_q + 6'h01;
        if (div_q == 6'(SYN_HALF_DIV - 1))
        begin
          sDat_d = cfg_q[SYN_WORD_BITS - 1];
          sClk_d = 1'b0;
        end
        else if (div_q == 6'(2 * SYN_HALF_DIV - 1))
        begin
          div_d = '0;
          sClk_d = 1'b1;
          cfg_d = {cfg_q[20:0], 1'b0};
          sbit_d = sbit_q + 5'h01;
          if (sbit_q == 5'(SYN_GROUP_BITS - 1))
            st_d = C_STROBE;
        end
      end
      C_STROBE:
      begin
        sClk_d = 1'b0;
        sStb_d = 1'b1;
        grp_d = 1'b1;
        sbit_d = '0;
        div_d = '0;
        st_d = grp_q ? C_LOCK : C_SHIFT;
        tmr_d = TIMER_W'(LOCK_CYC);
      end
      C_LOCK:
        if (tmr_q == '0)
        begin
          rcvOn_d = !isTx_q;
          xmtOn_d = isTx_q;
          tmr_d = TIMER_W'(SETTLE_CYC);
          st_d = C_SWITCH;
        end
      C_SWITCH:
        if (tmr_q == '0)
        begin
          st_d = C_DATA;
          tmr_d = TIMER_W'(MSG_LIMIT_CYC);
        end
      C_DATA:
      begin
        if (isTx_q)
        begin
          if (txValid && !tBusy_q && left_q != '0)
          begin
            txGo = 1'b1;
            left_d = left_q - 8'h01;
          end
          if (left_q == '0 && !tBusy_q)
            st_d = C_DONE;
        end
        else if ((rAccept && left_q == 8'h01) || tmr_q == '0 || left_q == '0)
          st_d = C_DONE;
        if (!isTx_q && rAccept)
          left_d = left_q - 8'h01;
      end
      C_DONE:
      begin
        rfOn_d = 1'b0;
        xmtOn_d = 1'b0;
        rcvOn_d = 1'b0;
        st_d = C_IDLE;
      end
      default:
        st_d = C_IDLE;
    endcase
  end
  // ****************************************************************
  // serial transmitter
  // ****************************************************************
  always_comb
  begin
    baud_d = baud_q;
    tbit_d = tbit_q;
    frame_d = frame_q;
    line_d = line_q;
    tBusy_d = tBusy_q;
    if (txGo)
    begin
      tBusy_d = 1'b1;
      frame_d = {1'b1, (^txData) ^ PARITY_ODD, txData, 1'b0};
      tbit_d = '0;
      baud_d = '0;
      line_d = 1'b0;
    end
    else if (tBusy_q)
    begin
      if (baud_q != 16'(BAUD_DIV - 1))
        baud_d = baud_q + 16'h0001;
      else
      begin
        baud_d = '0;
        tbit_d = tbit_q + 4'h1;
        if (tbit_q == 4'(FRAME_BITS - 1))
        begin
          tBusy_d = 1'b0;
          line_d = 1'b1;
        end
        else
          line_d = frame_q[tbit_q + 4'h1];
      end
    end
  end
  assign txReady = txGo;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st_q <= C_IDLE;
      isTx_q <= 1'b0;
      rfOn_q <= 1'b0;
      rcvOn_q <= 1'b0;
      xmtOn_q <= 1'b0;
      sClk_q <= 1'b0;
      sDat_q <= 1'b0;
      sStb_q <= 1'b0;
      grp_q <= 1'b0;
      tmr_q <= '0;
      sbit_q <= '0;
      div_q <= '0;
      cfg_q <= '0;
      left_q <= '0;
      lenErr_q <= 1'b0;
      baud_q <= '0;
      tbit_q <= '0;
      frame_q <= '0;
      line_q <= 1'b1;
      tBusy_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      isTx_q <= isTx_d;
      rfOn_q <= rfOn_d;
      rcvOn_q <= rcvOn_d;
      xmtOn_q <= xmtOn_d;
      sClk_q <= sClk_d;
      sDat_q <= sDat_d;
      sStb_q <= sStb_d;
      grp_q <= grp_d;
      tmr_q <= tmr_d;
      sbit_q <= sbit_d;
      div_q <= div_d;
      cfg_q <= cfg_d;
      left_q <= left_d;
      lenErr_q <= lenErr_d;
      baud_q <= baud_d;
      tbit_q <= tbit_d;
      frame_q <= frame_d;
      line_q <= line_d;
      tBusy_q <= tBusy_d;
    end
  end
  assign link.radioEnable = rfOn_q;
  assign link.receiverEnable = rcvOn_q;
  assign link.transmitterEnable = xmtOn_q;
  assign link.synthShiftClock = sClk_q;
  assign link.synthSerialBits = sDat_q;
  assign link.synthLoadStrobe = sStb_q;
  assign link.radioTxSerialIn = line_q;
  assign busy = st_q != C_IDLE;
  assign lenError = lenErr_q;
  // ****************************************************************
  // serial receiver
  // ****************************************************************
  assign rAccept = rValid && rxReady && st_q == C_DATA && !isTx_q;
  assign rxValid = rValid && st_q == C_DATA && !isTx_q;
  srls_uart_rx uRx (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(rfOn_q && rcvOn_q && st_q == C_DATA),
    .serialIn(link.radioRxSerialOut),
    .outData(rxData),
    .outErr(rxErr),
    .outValid(rValid),
    .outReady(rxReady || isTx_q)
  );
endmodule

// [rtl/srls_radio_end.sv]
// radio end: synthesizer capture, uart both ways, stale byte flush
`timescale 1ns/1ps
module srls_radio_end
  import srls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  srls_link_if.radio link,
  output logic [21:0] synthWord,
  output logic synthLocked,
  input wire srls_pkg::srls_byte_t airTxData,
  input wire logic airTxValid,
  output logic airTxReady,
  output srls_pkg::srls_byte_t airRxData,
  output logic airRxErr,
  output logic airRxValid,
  input wire logic airRxReady
);
  import srls_pkg::*;
  logic [1:0] syn_q [4];
  logic sClk, sDat, sStb, sClkOld_q, sStbOld_q;
  logic [10:0] grp_q, grp_d;
  logic [21:0] word_q, word_d;
  logic half_q, half_d, lock_q, lock_d;
  logic [23:0] lockCnt_q, lockCnt_d;
  logic [15:0] baud_q, baud_d;
  logic [3:0] bit_q, bit_d;
  logic [10:0] frame_q, frame_d;
  logic txLine_q, txLine_d, busy_q, busy_d, flush_q, flush_d, rxValid;
  srls_byte_t rxData;
  logic rxErr;
  // synthesizer pins pass two flip-flops before use; radio enable does so only for the capture and lock logic
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < 4; i++)
        syn_q[i] <= '0;
    end
    else
    begin
      syn_q[0] <= {syn_q[0][0], link.synthShiftClock};
      syn_q[1] <= {syn_q[1][0], link.synthSerialBits};
      syn_q[2] <= {syn_q[2][0], link.synthLoadStrobe};
      syn_q[3] <= {syn_q[3][0], link.radioEnable};
    end
  end
  assign sClk = syn_q[0][1];
  assign sDat = syn_q[1][1];
  assign sStb = syn_q[2][1];
  always_comb
  begin
    grp_d = grp_q;
    word_d = word_q;
    half_d = half_q;
    lock_d = lock_q;
    lockCnt_d = lockCnt_q;
    if (!syn_q[3][1])
    begin
      half_d = 1'b0;
      lock_d = 1'b0;
      lockCnt_d = '0;
    end
    else
    begin
      if (sClk && !sClkOld_q)
        grp_d = {grp_q[9:0], sDat};
      if (sStb && !sStbOld_q)
      begin
        half_d = !half_q;
        if (half_q)
        begin
          word_d = {word_q[10:0], grp_q};
          lockCnt_d = 24'(LOCK_CYC / 2);
        end
        else
          word_d = {word_q[10:0], grp_q};
      end
      else if (lockCnt_q != '0)
      begin
        lockCnt_d = lockCnt_q - 24'h000001;
        if (lockCnt_q == 24'h000001)
          lock_d = 1'b1;
      end
    end
  end
  // lock holds while the radio is on, so the transmit path keeps its bytes
  assign flush_d = !lock_q;
  always_comb
  begin
    baud_d = baud_q;
    bit_d = bit_q;
    frame_d = frame_q;
    txLine_d = txLine_q;
    busy_d = busy_q;
    if (!busy_q)
    begin
      txLine_d = 1'b1;
      if (airTxValid && lock_q && link.radioEnable && link.receiverEnable)
      begin
        busy_d = 1'b1;
        frame_d = {1'b1, (^airTxData) ^ PARITY_ODD, airTxData, 1'b0};
        bit_d = '0;
        baud_d = '0;
      end
    end
    else if (baud_q != 16'(BAUD_DIV - 1))
      baud_d = baud_q + 16'h0001;
    else
    begin
      baud_d = '0;
      bit_d = bit_q + 4'h1;
      if (bit_q == 4'(FRAME_BITS - 1))
        busy_d = 1'b0;
    end
    if (busy_q && baud_q == '0)
      txLine_d = frame_q[bit_q];
  end
  assign airTxReady = !busy_q && lock_q && link.radioEnable && link.receiverEnable;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sClkOld_q <= 1'b0;
      sStbOld_q <= 1'b0;
      grp_q <= '0;
      word_q <= '0;
      half_q <= 1'b0;
      lock_q <= 1'b0;
      lockCnt_q <= '0;
      baud_q <= '0;
      bit_q <= '0;
      frame_q <= '0;
      txLine_q <= 1'b1;
      busy_q <= 1'b0;
      flush_q <= 1'b1;
    end
    else
    begin
      sClkOld_q <= sClk;
      sStbOld_q <= sStb;
      grp_q <= grp_d;
      word_q <= word_d;
      half_q <= half_d;
      lock_q <= lock_d;
      lockCnt_q <= lockCnt_d;
      baud_q <= baud_d;
      bit_q <= bit_d;
      frame_q <= frame_d;
      txLine_q <= txLine_d;
      busy_q <= busy_d;
      flush_q <= flush_d;
    end
  end
  assign link.radioRxSerialOut = txLine_q;
  assign synthWord = word_q;
  assign synthLocked = lock_q;
  srls_uart_rx uRx (
    .sys_clk(sys_clk),
    .reset(reset),
    .enable(link.radioEnable & link.transmitterEnable),
    .serialIn(link.radioTxSerialIn),
    .outData(rxData),
    .outErr(rxErr),
    .outValid(rxValid),
    .outReady(airRxReady || flush_q)
  );
  assign airRxValid = rxValid && !flush_q;
  assign airRxData = rxData;
  assign airRxErr = rxErr;
endmodule

// [rtl/srls_uart_rx.sv]
// serial receiver with parity and stop check, two-entry output buffer
`timescale 1ns/1ps
module srls_uart_rx
  import srls_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic serialIn,
  output srls_pkg::srls_byte_t outData,
  output logic outErr,
  output logic outValid,
  input wire logic outReady
);
  import srls_pkg::*;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_BITS = 2'b01} srls_rx_e;
  srls_rx_e state_q, state_d;
  logic sync1_q, sync2_q;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [9:0] shf_q, shf_d;
  logic push;
  logic [8:0] pushWord;
  logic [8:0] buf_q [2];
  logic [8:0] buf_d [2];
  logic [1:0] fill_q, fill_d;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
    end
    else
    begin
      sync1_q <= serialIn;
      sync2_q <= sync1_q;
    end
  end
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    shf_d = shf_q;
    push = 1'b0;
    pushWord = '0;
    unique case (state_q)
      S_IDLE:
      begin
        if (enable && !sync2_q)
        begin
          state_d = S_BITS;
          cnt_d = 16'(BAUD_DIV / 2);
          bit_d = '0;
        end
      end
      S_BITS:
      begin
        if (cnt_q != 16'h0000)
          cnt_d = cnt_q - 16'h0001;
        else
        begin
          cnt_d = 16'(BAUD_DIV - 1);
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h0)
          begin
            if (sync2_q)
              state_d = S_IDLE;
          end
          else if (bit_q == 4'(FRAME_BITS - 1))
          begin
            state_d = S_IDLE;
            push = 1'b1;
            pushWord = {(sync2_q != 1'b1) || ((^shf_q[9:1]) != PARITY_ODD),
              shf_q[8:1]};
          end
          else
            shf_d = {sync2_q, shf_q[9:1]};
        end
      end
    endcase
  end
  // two-entry buffer: words drop only when full; no back-pressure reaches the sender
  always_comb
  begin
    fill_d = fill_q;
    buf_d = buf_q;
    if (outValid && outReady)
    begin
      buf_d[0] = buf_q[1];
      fill_d = fill_q - 2'h1;
    end
    if (push && (fill_d != 2'h2))
    begin
      buf_d[fill_d[0]] = pushWord;
      fill_d = fill_d + 2'h1;
    end
  end
  assign outValid = fill_q != 2'h0;
  assign outData = buf_q[0][7:0];
  assign outErr = buf_q[0][8];
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      shf_q <= '0;
      fill_q <= '0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shf_q <= shf_d;
      fill_q <= fill_d;
      buf_q <= buf_d;
    end
  end
endmodule

// [test/srls_link_checker.sv]
// concurrent checks on the controller-to-radio pin bundle
`timescale 1ns/1ps
module srls_link_checker (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic radioEnable,
  input wire logic receiverEnable,
  input wire logic transmitterEnable,
  input wire logic synthShiftClock,
  input wire logic synthSerialBits,
  input wire logic synthLoadStrobe,
  input wire logic radioTxSerialIn,
  input wire logic radioRxSerialOut
);
  import srls_pkg::*;
  // ********************
  // helper counters
  // ********************
  logic prevShift_q;
  logic [4:0] shiftCnt_q;
  logic [23:0] strobeAge_q;
  logic [23:0] xmitAge_q;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      prevShift_q <= 1'h0;
      shiftCnt_q <= 5'h00;
      strobeAge_q <= 24'h000000;
      xmitAge_q <= 24'h000000;
    end
    else
    begin
      prevShift_q <= synthShiftClock;
      // shift clock rises since the radio was switched on
      if (!radioEnable)
        shiftCnt_q <= 5'h00;
      else if (synthShiftClock && !prevShift_q)
        shiftCnt_q <= shiftCnt_q + 5'h01;
      if (synthLoadStrobe)
        strobeAge_q <= 24'h000000;
      else if (strobeAge_q != 24'hFFFFFF)
        strobeAge_q <= strobeAge_q + 24'h000001;
      if (!transmitterEnable)
        xmitAge_q <= 24'h000000;
      else if (xmitAge_q != 24'hFFFFFF)
        xmitAge_q <= xmitAge_q + 24'h000001;
    end
  end
  // ********************
  // properties
  // ********************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  property p_synth_needs_enables;
    synthLoadStrobe |-> radioEnable && receiverEnable && !transmitterEnable;
  endproperty
  a_synth_needs_enables: assert property (p_synth_needs_enables)
    else $error("strobe without receive and radio enable");
  property p_group_size;
    synthLoadStrobe |-> shiftCnt_q == 5'h0B || shiftCnt_q == 5'h16;
  endproperty
  a_group_size: assert property (p_group_size)
    else $error("strobe not after 11 or 22 shift clocks");
  property p_strobe_pulse;
    synthLoadStrobe |=> !synthLoadStrobe;
  endproperty
  a_strobe_pulse: assert property (p_strobe_pulse)
    else $error("load strobe longer than one cycle");
  property p_lock_wait;
    $rose(transmitterEnable) |-> strobeAge_q >= LOCK_CYC - 2 && strobeAge_q <= LOCK_CYC + 2;
  endproperty
  a_lock_wait: assert property (p_lock_wait)
    else $error("transmit enabled without the lock wait");
  property p_tx_swap;
    transmitterEnable |-> radioEnable && !receiverEnable;
  endproperty
  a_tx_swap: assert property (p_tx_swap)
    else $error("transmit enable with receive enable or radio off");
  property p_tx_settle;
    transmitterEnable && xmitAge_q < SETTLE_CYC - 2 |-> radioTxSerialIn;
  endproperty
  a_tx_settle: assert property (p_tx_settle)
    else $error("serial data during settling wait");
  property p_tx_idle;
    !transmitterEnable |-> radioTxSerialIn;
  endproperty
  a_tx_idle: assert property (p_tx_idle)
    else $error("serial data outside transmit");
  property p_tx_end;
    $fell(transmitterEnable) |-> !radioEnable && !receiverEnable;
  endproperty
  a_tx_end: assert property (p_tx_end)
    else $error("radio left on after transmit");
  property p_radio_quiet;
    !radioEnable |-> radioRxSerialOut;
  endproperty
  a_radio_quiet: assert property (p_radio_quiet)
    else $error("radio sends while switched off");
  property p_synth_idle;
    !radioEnable |-> !synthShiftClock && !synthLoadStrobe;
  endproperty
  a_synth_idle: assert property (p_synth_idle)
    else $error("synthesizer pins move while radio off");
endmodule

// [test/tb_sensor_radio_link_sequencer.sv]
// self-checking bench: controller and radio ends joined over the link bundle
`timescale 1ns/1ps
module tb_sensor_radio_link_sequencer;
  import srls_pkg::*;
  // ********************
  // rows and bench state
  // ********************
  typedef struct packed {srls_byte_t din; logic expErr;} srls_row_s;
  localparam int ROWS = 3;
  localparam int LIMIT = 700000;
  srls_row_s rows [ROWS] = '{'{8'hA5, 1'h0}, '{8'h00, 1'h0}, '{8'hFF, 1'h0}};
  logic sys_clk, reset, startTx, startRx, txValid, txReady, rxErr, rxValid, rxReady;
  logic busy, lenError, synthLocked, airTxValid, airTxReady, airRxErr, airRxValid;
  logic airRxReady;
  logic [21:0] synthCfg, synthWord;
  logic [7:0] msgLen;
  srls_byte_t txData, rxData, airTxData, airRxData;
  logic [8:0] airQ [$];
  logic [8:0] rxQ [$];
  int errors = 0, num_checks = 0, cycles = 0, strobes = 0, base, t0;
  srls_link_if linkBus();
  srls_ctrl_end srls_ctrl_end_inst (.sys_clk(sys_clk), .reset(reset), .link(linkBus),
    .startTx(startTx), .startRx(startRx), .synthCfg(synthCfg), .msgLen(msgLen),
    .txData(txData), .txValid(txValid), .txReady(txReady), .rxData(rxData), .rxErr(rxErr),
    .rxValid(rxValid), .rxReady(rxReady), .busy(busy), .lenError(lenError));
  srls_radio_end srls_radio_end_inst (.sys_clk(sys_clk), .reset(reset), .link(linkBus),
    .synthWord(synthWord), .synthLocked(synthLocked), .airTxData(airTxData),
    .airTxValid(airTxValid), .airTxReady(airTxReady), .airRxData(airRxData),
    .airRxErr(airRxErr), .airRxValid(airRxValid), .airRxReady(airRxReady));
  srls_link_checker srls_link_checker_inst (.sys_clk(sys_clk), .reset(reset),
    .radioEnable(linkBus.radioEnable), .receiverEnable(linkBus.receiverEnable),
    .transmitterEnable(linkBus.transmitterEnable), .synthShiftClock(linkBus.synthShiftClock),
    .synthSerialBits(linkBus.synthSerialBits), .synthLoadStrobe(linkBus.synthLoadStrobe),
    .radioTxSerialIn(linkBus.radioTxSerialIn), .radioRxSerialOut(linkBus.radioRxSerialOut));
  // ********************
  // tasks
  // ********************
  task automatic check(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'h1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // both senders leave valid high so back-to-back bytes need no gap
  task automatic sendByte(input srls_byte_t d);
    txData = d;
    txValid = 1'h1;
    @(posedge sys_clk);
    while (txReady !== 1'h1) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic sendAir(input srls_byte_t d);
    airTxData = d;
    airTxValid = 1'h1;
    @(posedge sys_clk);
    while (airTxReady !== 1'h1) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  // ********************
  // clock, monitors, timeout
  // ********************
  initial
  begin
    sys_clk = 1'h0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    if (airRxValid === 1'h1 && airRxReady === 1'h1) airQ.push_back({airRxErr, airRxData});
    if (rxValid === 1'h1 && rxReady === 1'h1) rxQ.push_back({rxErr, rxData});
    if (linkBus.synthLoadStrobe === 1'h1) strobes <= strobes + 1;
    if (cycles == LIMIT)
    begin
      check(1'h0, "timeout");
      summarize();
    end
  end
  // ********************
  // main sequence
  // ********************
  initial
  begin
    reset = 1'h1;
    {startTx, startRx, txValid, rxReady, airTxValid, airRxReady} = 6'h00;
    {txData, airTxData, msgLen} = 24'h000000;
    synthCfg = 22'h2A5C3B;
    repeat (6) @(negedge sys_clk);
    check(linkBus.radioEnable === 1'h0 && linkBus.receiverEnable === 1'h0 &&
      linkBus.transmitterEnable === 1'h0 && busy === 1'h0, "enables in reset");
    check(linkBus.radioTxSerialIn === 1'h1 && linkBus.radioRxSerialOut === 1'h1, "idle lines");
    reset = 1'h0;
    msgLen = 8'(MAX_MSG_BYTES + 1);
    startTx = 1'h1;
    @(negedge sys_clk);
    startTx = 1'h0;
    repeat (3) @(negedge sys_clk);
    check(lenError === 1'h1 && linkBus.radioEnable === 1'h0 && busy === 1'h0,
      "long msg");
    msgLen = 8'(ROWS);
    startTx = 1'h1;
    @(negedge sys_clk);
    startTx = 1'h0;
    @(negedge sys_clk);
    check(linkBus.radioEnable === 1'h1 && linkBus.receiverEnable === 1'h1, "tx enables");
    while (linkBus.transmitterEnable !== 1'h1) @(negedge sys_clk);
    check(synthWord === synthCfg && synthLocked === 1'h1, "synth word or lock");
    check(linkBus.receiverEnable === 1'h0 && linkBus.radioEnable === 1'h1,
      "tx switch");
    // radio side stalls until the last byte is taken, filling its buffer
    foreach (rows[i]) sendByte(rows[i].din);
    txValid = 1'h0;
    airRxReady = 1'h1;
    while (busy !== 1'h0) @(negedge sys_clk);
    check(linkBus.radioEnable === 1'h0 && linkBus.transmitterEnable === 1'h0, "tx end");
    while (airQ.size() < ROWS) @(negedge sys_clk);
    foreach (rows[i])
      check(airQ[i] === {rows[i].expErr, rows[i].din}, "tx byte");
    synthCfg = 22'h15A3C4;
    msgLen = 8'h02;
    base = strobes;
    t0 = cycles;
    startRx = 1'h1;
    @(negedge sys_clk);
    startRx = 1'h0;
    while (linkBus.synthShiftClock !== 1'h1) @(negedge sys_clk);
    check(cycles - t0 >= SETTLE_CYC, "synth loaded before rx wait");
    while (strobes < base + 2) @(negedge sys_clk);
    // the radio sees the strobe through its two-stage synchroniser
    repeat (4) @(negedge sys_clk);
    check(synthWord === synthCfg, "rx synth word");
    repeat (LOCK_CYC + SETTLE_CYC + 50) @(negedge sys_clk);
    check(linkBus.receiverEnable === 1'h1 && linkBus.transmitterEnable === 1'h0,
      "rx path");
    // controller consumer stalls, so both bytes sit in its buffer
    for (int i = 0; i < 2; i++) sendAir(rows[i].din);
    airTxValid = 1'h0;
    repeat (FRAME_CYC + 20) @(negedge sys_clk);
    check(busy === 1'h1 && rxValid === 1'h1 && rxQ.size() == 0, "rx stall");
    rxReady = 1'h1;
    while (busy !== 1'h0) @(negedge sys_clk);
    check(linkBus.radioEnable === 1'h0 && linkBus.receiverEnable === 1'h0, "rx end");
    check(rxQ.size() == 2, "rx count");
    for (int i = 0; i < 2; i++)
      check(rxQ[i] === {rows[i].expErr, rows[i].din}, "rx byte");
    summarize();
  end
endmodule
